/* File: include/encoder_counter_pkg.sv */
// Constants and types shared by the incremental encoder counter
package encoder_counter_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  // Period measurement resolution
  localparam int unsigned PERIOD_TICK_NS    = 200;
  localparam int unsigned PERIOD_TICK_CYC   = PERIOD_TICK_NS / CLK_PERIOD_NS;
  // Activity indicator timeout
  localparam int unsigned ACTIVITY_TMO_MS   = 100;
  localparam int unsigned ACTIVITY_TMO_CYC  =
    ACTIVITY_TMO_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned COUNT_W           = 16;
  localparam int unsigned PERIOD_W          = 24;
  localparam int unsigned IMAGE_BYTES       = 6;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  localparam logic [15:0] COUNT_MAX         = 16'hFFFF;

  // Evaluation factor encoding
  typedef enum logic [1:0] {
    EVAL_X1 = 2'b00,
    EVAL_X2 = 2'b01,
    EVAL_X4 = 2'b10
  } eval_mode_t;

  // Operating mode encoding
  typedef enum logic [1:0] {
    MODE_ENCODER = 2'b00,
    MODE_UPDOWN  = 2'b01,
    MODE_PERIOD  = 2'b10
  } op_mode_t;

  localparam eval_mode_t EVAL_RESET = EVAL_X4;
  localparam op_mode_t   MODE_RESET = MODE_ENCODER;
  localparam logic       DIFF_RESET = 1'b1;
endpackage

/* File: verilog/incremental_encoder_counter.sv */
// Incremental encoder counter with latch, gate and period measurement
`timescale 1ns/1ns
// How it works
// - 16-bit position counter from quadrature decoder, 16-bit latch on index
// - Evaluation x1, x2 or x4; inputs single-ended or complementary
// - After reset: x4 quadrature evaluation with complementary inputs
// - Mode setting picks encoder mode (default), up/down counter mode or period mode
// - Up/down mode: count on phase A rise; B=0 up, B=1 down
// - Up/down mode: index is gate, 0 counts, 1 holds
// - External gate high holds the counter; low resumes counting
// - External latch arm set: rising external latch copies counter
// - Index latch arm set: index rise captures counter into latch, except in up/down mode
// - Period between successive phase A rises timed in 200 ns units
// - Overflow and underflow flagged in status
// - Six byte input and output images, status/control byte lowest
// - First word carries count; host writes it to preset counter
// - Second input word shows latch value
// - Period mode: period spans spare middle byte plus latch word
// - Activity indicator on during exchange, off after 100 ms idle
// - Alarm input active low; undriven high means no alarm
// - Counter sustains four million increments per second in x4
module incremental_encoder_counter
  import encoder_counter_pkg::*;
#(
  parameter int unsigned ACT_TMO_CYC = ACTIVITY_TMO_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Encoder pins, true and complement
  input  wire logic        phase_a_in,
  input  wire logic        phase_a_n_in,
  input  wire logic        phase_b_in,
  input  wire logic        phase_b_n_in,
  input  wire logic        index_in,
  input  wire logic        index_n_in,
  input  wire logic        alarm_n_in,
  input  wire logic        external_latch_input_in,
  input  wire logic        external_gate_input_in,
  // Configuration
  input  wire logic [1:0]  eval_mode_in,
  input  wire logic [1:0]  op_mode_in,
  input  wire logic        diff_inputs_in,
  input  wire logic        config_valid_in,
  // Host output image, one exchange per strobe
  input  wire logic        exchange_in,
  input  wire logic [7:0]  control_byte_in,
  input  wire logic [15:0] counter_data_word_in,
  input  wire logic [7:0]  period_extension_byte_in,
  input  wire logic [15:0] latch_data_word_in,
  // Host input image
  output logic [7:0]       status_byte_out,
  output logic [15:0]      counter_data_word_out,
  output logic [7:0]       period_extension_byte_out,
  output logic [15:0]      latch_data_word_out,
  output logic             activity_out
);

  // Control byte bits
  localparam int unsigned CTL_IDX_ARM  = 0;
  localparam int unsigned CTL_EXT_ARM  = 1;
  localparam int unsigned CTL_PRESET   = 2;
  // Status byte bits
  localparam int unsigned ST_IDX_DONE  = 0;
  localparam int unsigned ST_EXT_DONE  = 1;
  localparam int unsigned ST_PRESET_AK = 2;
  localparam int unsigned ST_OVF       = 3;
  localparam int unsigned ST_UNF       = 4;
  localparam int unsigned ST_ALARM     = 5;
  localparam int unsigned ST_GATE      = 6;
  localparam int unsigned ST_PERIOD_OK = 7;
  localparam int unsigned SYNC_W       = 6;
  // Alarm line idles high, so reset its stages high: no false alarm
  localparam logic [5:0]  SYNC_IDLE    = 6'h08;
  localparam logic [4:0]  TICK_LAST    = 5'(PERIOD_TICK_CYC - 1);
  localparam logic [23:0] PERIOD_MAX   = 24'hFFFFFF;
  localparam logic [26:0] ACT_LAST     = 27'(ACT_TMO_CYC - 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin selection and synchronisers

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] prev_q;
  logic              diff_q;
  eval_mode_t        eval_q;
  op_mode_t          mode_q;

  // Complementary mode takes a line high only when true is high and complement low
  function automatic logic pick(input logic t, input logic c,
                                input logic diff);
    pick = diff ? (t & ~c) : t;
  endfunction

  always_comb begin
    pin_raw[0] = pick(phase_a_in, phase_a_n_in, diff_q);
    pin_raw[1] = pick(phase_b_in, phase_b_n_in, diff_q);
    pin_raw[2] = pick(index_in, index_n_in, diff_q);
    pin_raw[3] = alarm_n_in;
    pin_raw[4] = external_latch_input_in;
    pin_raw[5] = external_gate_input_in;
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
      prev_q  <= SYNC_IDLE;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic a_s, b_s, c_s, a_rise, c_rise, ext_rise, gate_s, alarm_s;
  assign a_s      = sync2_q[0];
  assign b_s      = sync2_q[1];
  assign c_s      = sync2_q[2];
  assign a_rise   = sync2_q[0] & ~prev_q[0];
  assign c_rise   = sync2_q[2] & ~prev_q[2];
  assign ext_rise = sync2_q[4] & ~prev_q[4];
  assign gate_s   = sync2_q[5];
  assign alarm_s  = ~sync2_q[3];

  //////////////////////////////////////////////////////////////////////////
  // Configuration

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      eval_q <= EVAL_RESET;
      mode_q <= MODE_RESET;
      diff_q <= DIFF_RESET;
    end else if (config_valid_in) begin
      eval_q <= eval_mode_t'(eval_mode_in);
      mode_q <= op_mode_t'(op_mode_in);
      diff_q <= diff_inputs_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Quadrature decoder

  logic step, up;
  logic a_chg, b_chg;
  assign a_chg = sync2_q[0] ^ prev_q[0];
  assign b_chg = sync2_q[1] ^ prev_q[1];

  always_comb begin
    step = 1'b0;
    up   = 1'b0;
    case (mode_q)
      MODE_UPDOWN: begin
        step = a_rise & ~c_s;
        up   = ~b_s;
      end
      default: begin
        // Direction from phase relation, A leads B counts up
        case (eval_q)
          EVAL_X1: begin
            step = a_chg & ~b_s;
            up   = a_s;
          end
          EVAL_X2: begin
            step = a_chg;
            up   = a_s ^ b_s;
          end
          default: begin
            step = a_chg | b_chg;
            up   = a_chg ? (a_s ^ b_s) : ~(a_s ^ b_s);
          end
        endcase
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter, preset and wrap flags

  logic [15:0] count_q;
  logic        ovf_q, unf_q, preset_ak_q;
  logic        do_count, preset_req;
  assign do_count   = step & ~gate_s;
  assign preset_req = exchange_in & control_byte_in[CTL_PRESET];

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= COUNT_RESET;
    end else if (preset_req) begin
      count_q <= counter_data_word_in;
    end else if (do_count) begin
      count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001;
    end
  end

  // Flags set on wrap; a new wrap wins over the clearing exchange
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (!preset_req && do_count && up && count_q == COUNT_MAX) begin
        ovf_q <= 1'b1;
      end else if (exchange_in) begin
        ovf_q <= 1'b0;
      end
      if (!preset_req && do_count && !up && count_q == COUNT_RESET) begin
        unf_q <= 1'b1;
      end else if (exchange_in) begin
        unf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      preset_ak_q <= 1'b0;
    end else if (exchange_in) begin
      preset_ak_q <= control_byte_in[CTL_PRESET];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Latch register

  logic [15:0] latch_q;
  logic        idx_done_q, ext_done_q, idx_hit, ext_hit;
  assign idx_hit = control_byte_in[CTL_IDX_ARM] & c_rise
                   & (mode_q != MODE_UPDOWN);
  assign ext_hit = control_byte_in[CTL_EXT_ARM] & ext_rise;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      latch_q <= COUNT_RESET;
    end else if (idx_hit || ext_hit) begin
      latch_q <= count_q;
    end
  end

  // Done flags follow the arm bits; dropping an arm clears its flag
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idx_done_q <= 1'b0;
      ext_done_q <= 1'b0;
    end else begin
      if (idx_hit) begin
        idx_done_q <= 1'b1;
      end else if (!control_byte_in[CTL_IDX_ARM]) begin
        idx_done_q <= 1'b0;
      end
      if (ext_hit) begin
        ext_done_q <= 1'b1;
      end else if (!control_byte_in[CTL_EXT_ARM]) begin
        ext_done_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Period measurement

  logic [4:0]  tick_q;
  logic [23:0] run_q, period_q;
  logic        period_ok_q, seen_q;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_q      <= '0;
      run_q       <= '0;
      period_q    <= '0;
      period_ok_q <= 1'b0;
      seen_q      <= 1'b0;
    end else if (a_rise) begin
      tick_q <= '0;
      run_q  <= '0;
      seen_q <= 1'b1;
      if (seen_q) begin
        period_q    <= run_q;
        period_ok_q <= 1'b1;
      end
    end else if (tick_q == TICK_LAST) begin
      tick_q <= '0;
      if (run_q != PERIOD_MAX) begin
        run_q <= run_q + 24'h000001;
      end
    end else begin
      tick_q <= tick_q + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Activity indicator

  logic [26:0] idle_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_q       <= '0;
      activity_out <= 1'b0;
    end else if (exchange_in) begin
      idle_q       <= '0;
      activity_out <= 1'b1;
    end else if (idle_q == ACT_LAST) begin
      activity_out <= 1'b0;
    end else begin
      idle_q <= idle_q + 27'h0000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input image registers

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_byte_out           <= 8'h00;
      counter_data_word_out     <= COUNT_RESET;
      period_extension_byte_out <= 8'h00;
      latch_data_word_out       <= COUNT_RESET;
    end else begin
      status_byte_out <= {period_ok_q, gate_s, alarm_s, unf_q, ovf_q,
                          preset_ak_q, ext_done_q, idx_done_q};
      counter_data_word_out <= count_q;
      if (mode_q == MODE_PERIOD) begin
        {period_extension_byte_out, latch_data_word_out} <= period_q;
      end else begin
        period_extension_byte_out <= 8'h00;
        latch_data_word_out       <= latch_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  a_gate_holds: assert property (@(posedge core_clk_in) disable iff (reset_in)
    gate_s && !preset_req |=> $stable(count_q))
    else $error("count moved while gate high");

  a_ud_step: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mode_q == MODE_UPDOWN && a_rise && !c_s && !b_s && !gate_s && !preset_req
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("up count missed");

  a_ud_index_gate: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    mode_q == MODE_UPDOWN && c_s && !preset_req |=> $stable(count_q))
    else $error("index gate ignored");

  a_preset_load: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    preset_req |=> ##1 counter_data_word_out == $past(counter_data_word_in, 2))
    else $error("preset not shown");

  a_ext_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ext_hit |=> latch_q == $past(count_q))
    else $error("external latch missed");

  a_idx_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
    idx_hit |=> latch_q == $past(count_q))
    else $error("index latch missed");

  a_latch_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !idx_hit && !ext_hit |=> $stable(latch_q))
    else $error("latch changed unarmed");

  a_ovf_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
    do_count && up && !preset_req && count_q == COUNT_MAX
    |=> ovf_q && count_q == COUNT_RESET ##1 status_byte_out[ST_OVF])
    else $error("overflow not flagged");

  a_unf_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
    do_count && !up && !preset_req && count_q == COUNT_RESET
    |=> unf_q ##1 status_byte_out[ST_UNF])
    else $error("underflow not flagged");

  a_alarm_map: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !sync2_q[3] |=> status_byte_out[ST_ALARM])
    else $error("alarm not reported");

  a_act_on: assert property (@(posedge core_clk_in) disable iff (reset_in)
    exchange_in |=> activity_out)
    else $error("activity not lit");

endmodule

/* File: dv/encoder_model.sv */
// Behavioural incremental encoder: quadrature, index and alarm lines
`timescale 1ns/1ns
module encoder_model (
  // Pacing clock
  input  wire logic clk_in,
  // Encoder lines, true and complement
  output logic      phase_a_out,
  output logic      phase_a_n_out,
  output logic      phase_b_out,
  output logic      phase_b_n_out,
  output logic      index_out,
  output logic      index_n_out,
  output logic      alarm_n_out
);
  // Complements mirror the true lines, as a line driver would
  assign phase_a_n_out = ~phase_a_out;
  assign phase_b_n_out = ~phase_b_out;
  assign index_n_out   = ~index_out;

  initial begin
    phase_a_out = 1'b0;
    phase_b_out = 1'b0;
    index_out   = 1'b0;
    alarm_n_out = 1'b1; // Pulled up when undriven
  end

  //////////////////////////////////////////////////////////////////////////
  // One edge every gap cycles; counting up means A leads B
  task automatic quad(input bit dn, input int edges, input int gap);
    logic nxt;
    for (int i = 0; i < edges; i++) begin
      repeat (gap) @(negedge clk_in);
      nxt         = dn ? phase_b_out : ~phase_b_out;
      phase_b_out = dn ? ~phase_a_out : phase_a_out;
      phase_a_out = nxt;
    end
  endtask

  // Pulses on A alone, high and low for gap cycles each
  task automatic pulse_a(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(negedge clk_in);
      phase_a_out = 1'b1;
      repeat (gap) @(negedge clk_in);
      phase_a_out = 1'b0;
    end
  endtask

  task automatic set_lines(input logic b, input logic idx, input logic al_n);
    @(negedge clk_in);
    phase_b_out = b;
    index_out   = idx;
    alarm_n_out = al_n;
  endtask
endmodule

/* File: dv/tb_incremental_encoder_counter.sv */
// Self-checking bench for the incremental encoder counter
`timescale 1ns/1ns
module tb_incremental_encoder_counter;
  import encoder_counter_pkg::*;
  localparam int unsigned TMO  = 50;
  // 25 cycles per edge is 4 million edges per second
  localparam int          EDGE = 25;

  typedef struct {
    logic [1:0]  ev;
    logic [1:0]  md;
    logic        df;
    int          n;
    bit          dn;
    logic [15:0] exp;
  } row_t;

  logic        core_clk_in;
  logic        reset_in;
  logic        a, a_n, b, b_n, idx, idx_n, alarm_n;
  logic        external_latch_input;
  logic        external_gate_input;
  logic [1:0]  eval_m;
  logic [1:0]  op_m;
  logic        diff;
  logic        cfg_v;
  logic        xchg_v;
  logic [7:0]  ctrl;
  logic [15:0] cnt_w;
  logic [7:0]  status;
  logic [15:0] cnt_o;
  logic [7:0]  pext;
  logic [15:0] lat_o;
  logic        act;
  int          n_mismatch;
  int          tests_run;
  row_t        rows[6];

  encoder_model enc (
    .clk_in(core_clk_in), .phase_a_out(a), .phase_a_n_out(a_n),
    .phase_b_out(b), .phase_b_n_out(b_n), .index_out(idx),
    .index_n_out(idx_n), .alarm_n_out(alarm_n)
  );

  incremental_encoder_counter #(.ACT_TMO_CYC(TMO)) uut (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .phase_a_in(a), .phase_a_n_in(a_n), .phase_b_in(b),
    .phase_b_n_in(b_n), .index_in(idx), .index_n_in(idx_n),
    .alarm_n_in(alarm_n),
    .external_latch_input_in(external_latch_input),
    .external_gate_input_in(external_gate_input),
    .eval_mode_in(eval_m), .op_mode_in(op_m), .diff_inputs_in(diff),
    .config_valid_in(cfg_v), .exchange_in(xchg_v),
    .control_byte_in(ctrl), .counter_data_word_in(cnt_w),
    .period_extension_byte_in(8'h00), .latch_data_word_in(16'h0000),
    .status_byte_out(status), .counter_data_word_out(cnt_o),
    .period_extension_byte_out(pext), .latch_data_word_out(lat_o),
    .activity_out(act)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Arm bits stay live after the strobe; preset is taken only on it
  task automatic xchg(input logic [7:0] c, input logic [15:0] v);
    @(negedge core_clk_in);
    ctrl   = c;
    cnt_w  = v;
    xchg_v = 1'b1;
    @(negedge core_clk_in);
    xchg_v = 1'b0;
    cyc(3);
  endtask

  task automatic cfg(input logic [1:0] ev, input logic [1:0] md,
                     input logic df);
    @(negedge core_clk_in);
    eval_m = ev;
    op_m   = md;
    diff   = df;
    cfg_v  = 1'b1;
    @(negedge core_clk_in);
    cfg_v  = 1'b0;
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk_in);
    n_mismatch++;
    $display("ERROR %0t run did not finish", $time);
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{EVAL_X4, MODE_ENCODER, 1'b1, 2, 1'b0, 16'h0008};
    rows[1] = '{EVAL_X2, MODE_ENCODER, 1'b0, 2, 1'b0, 16'h0004};
    rows[2] = '{EVAL_X1, MODE_ENCODER, 1'b1, 2, 1'b0, 16'h0002};
    rows[3] = '{EVAL_X4, MODE_ENCODER, 1'b1, 1, 1'b1, 16'hFFFC};
    rows[4] = '{EVAL_X1, MODE_UPDOWN, 1'b1, 3, 1'b0, 16'h0003};
    rows[5] = '{EVAL_X1, MODE_UPDOWN, 1'b1, 3, 1'b1, 16'hFFFD};
    {reset_in, external_latch_input, external_gate_input} = 3'b100;
    {eval_m, op_m, diff, cfg_v, xchg_v} = 7'b1000100;
    ctrl  = 8'h00;
    cnt_w = 16'h0000;
    cyc(10);
    reset_in = 1'b0;
    foreach (rows[i]) begin
      cfg(rows[i].ev, rows[i].md, rows[i].df);
      xchg(8'h04, 16'h0000);
      if (rows[i].md == MODE_UPDOWN) begin
        enc.set_lines(rows[i].dn, 1'b0, 1'b1);
        enc.pulse_a(rows[i].n, EDGE);
        enc.set_lines(1'b0, 1'b0, 1'b1);
      end else begin
        enc.quad(rows[i].dn, 4 * rows[i].n, EDGE);
      end
      cyc(8);
      chk(cnt_o, rows[i].exp, "count");
    end
    // Wrap in both directions
    cfg(EVAL_X4, MODE_ENCODER, 1'b1);
    xchg(8'h04, 16'hFFFF);
    enc.quad(1'b0, 1, EDGE);
    cyc(8);
    chk({status[3:2], cnt_o}, 24'h030000, "overflow");
    xchg(8'h04, 16'h0000);
    enc.quad(1'b1, 1, EDGE);
    cyc(8);
    chk({status[4], cnt_o}, 24'h01FFFF, "underflow");
    // External gate holds the count
    external_gate_input = 1'b1;
    enc.quad(1'b0, 4, EDGE);
    cyc(8);
    chk(cnt_o, 16'hFFFF, "gated count");
    chk(status[6], 1'b1, "gate shown");
    external_gate_input = 1'b0;
    enc.quad(1'b0, 4, EDGE);
    cyc(8);
    chk(cnt_o, 16'h0003, "gate released");
    // Index acts as gate in up/down mode
    cfg(EVAL_X4, MODE_UPDOWN, 1'b1);
    xchg(8'h04, 16'h0000);
    enc.set_lines(1'b0, 1'b1, 1'b1);
    enc.pulse_a(2, EDGE);
    cyc(8);
    chk(cnt_o, 16'h0000, "index gate");
    enc.set_lines(1'b0, 1'b0, 1'b1);
    enc.pulse_a(2, EDGE);
    cyc(8);
    chk(cnt_o, 16'h0002, "index gate open");
    // Index latch, then the latch must hold while counting goes on
    cfg(EVAL_X4, MODE_ENCODER, 1'b1);
    xchg(8'h05, 16'h1234);
    enc.quad(1'b0, 4, EDGE);
    enc.set_lines(1'b0, 1'b1, 1'b1);
    cyc(EDGE);
    enc.set_lines(1'b0, 1'b0, 1'b1);
    cyc(8);
    chk({status[0], lat_o}, 24'h011238, "index latch");
    enc.quad(1'b0, 2, EDGE);
    cyc(8);
    chk({cnt_o, lat_o[7:0]}, 24'h123A38, "latch held");
    // External latch ignored unarmed, taken when armed
    xchg(8'h00, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      external_latch_input = 1'b1;
      cyc(8);
      external_latch_input = 1'b0;
      cyc(4);
      chk({status[1], lat_o}, k ? 24'h01123A : 24'h001238, "ext");
      if (k == 0) xchg(8'h02, 16'h0000);
    end
    // Rises 400 cycles apart are 4000 ns, 20 ticks of 200 ns
    cfg(EVAL_X4, MODE_PERIOD, 1'b1);
    enc.pulse_a(3, 200);
    cyc(8);
    tests_run++;
    if (status[7] !== 1'b1 || ({pext, lat_o} !== 24'd20 &&
        {pext, lat_o} !== 24'd19 && {pext, lat_o} !== 24'd21)) begin
      n_mismatch++;
      $display("ERROR %0t period %h %h", $time, pext, lat_o);
    end
    enc.set_lines(1'b0, 1'b0, 1'b0);
    cyc(8);
    chk(status[5], 1'b1, "alarm low");
    enc.set_lines(1'b0, 1'b0, 1'b1);
    cyc(8);
    chk(status[5], 1'b0, "alarm released");
    // Activity indicator drops after the idle timeout
    xchg(8'h00, 16'h0000);
    cyc(TMO - 10);
    chk(act, 1'b1, "activity on");
    for (int k = 0; k <= 20 && act !== 1'b0; k++) begin
      cyc(1);
      if (k == 20) chk(act, 1'b0, "activity timeout");
    end
    // Mid-run reset returns to x4 complementary encoder mode
    reset_in = 1'b1;
    cyc(2);
    chk({status, cnt_o}, 24'h000000, "reset count");
    chk({pext, lat_o}, 24'h000000, "reset image");
    chk(act, 1'b0, "reset activity");
    reset_in = 1'b0;
    cyc(3);
    chk(status[5], 1'b0, "no alarm after reset");
    enc.quad(1'b0, 4, EDGE);
    cyc(8);
    chk(cnt_o, 16'h0004, "default x4");
    print_verdict();
  end
endmodule
